// ==== nco_defs.vh ====
`ifndef NCO_DEFS_VH
`define NCO_DEFS_VH

// ----------------------------------------------------------------
// Datapath widths
// ----------------------------------------------------------------
`define NCO_ACC_W 32
`define NCO_FREQ_W 64
`define NCO_PH_W 13
`define NCO_OUT_W 12
`define NCO_PH_TOP 19
`define NCO_QTR_W 11

// ----------------------------------------------------------------
// Pipeline delays in main clocks
// ----------------------------------------------------------------
`define NCO_TRANSFER_DLY 4
`define NCO_LOAD_DLY 5
`define NCO_ACC_DLY 4
`define NCO_PM_DLY 4

// ----------------------------------------------------------------
// Phase offset codes, in quarter turns
// ----------------------------------------------------------------
`define NCO_QT_0 2'h0
`define NCO_QT_90 2'h1
`define NCO_QT_180 2'h2
`define NCO_QT_270 2'h3

// ----------------------------------------------------------------
// Sine approximation
// ----------------------------------------------------------------
`define NCO_MID 12'h800
`define NCO_HALF_X 12'h800
`define NCO_MAG_MAX 11'h7ff
`define NCO_C1 32'h0000_1922
`define NCO_C3 32'h0000_0a56
`define NCO_C5 32'h0000_0146
`define NCO_FRAC 11
`define NCO_CSH 12

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define NCO_REG_CTRL 8'h00
`define NCO_REG_PHASE 8'h04
`define NCO_REG_TUNE 8'h08
`define NCO_REG_FREQ_LO 8'h0c
`define NCO_REG_FREQ_HI 8'h10
`define NCO_REG_SAMPLE 8'h14
`define NCO_CTRL_RST 3'h0
`define NCO_CTRL_SOFT_PM_EN 0
`define NCO_CTRL_SOFT_PM_LO 1
`define NCO_CTRL_W 3

`endif

// ==== nco_dly.v ====
module nco_dly #(
    parameter W = 1,
    parameter D = 4,
    parameter [W-1:0] RST = {W{1'b0}}
) (
    input wire mclk_i,
    input wire rst_n_i,
    input wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);
    reg [W-1:0] stage [0:D-1];
    genvar g;
    generate
        for (g = 0; g < D; g = g + 1) begin : g_stage
            always @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    stage[g] <= RST;
                end else if (g == 0) begin
                    stage[g] <= d_i;
                end else begin
                    stage[g] <= stage[(g == 0) ? 0 : g - 1];
                end
            end
        end
    endgenerate
    assign q_o = stage[D-1];
endmodule

// ==== nco_sine_rom.v ====
`include "nco_defs.vh"

module nco_sine_rom (
    input wire mclk_i,
    input wire rst_n_i,
    input wire [`NCO_PH_W-1:0] phase_i,
    output reg [`NCO_OUT_W-1:0] sample_o
);
    // ----------------------------------------------------------------
    // Quarter-wave fold
    // ----------------------------------------------------------------
    wire [1:0] quad = phase_i[`NCO_PH_W-1:`NCO_PH_W-2];
    wire [11:0] x_lo = {1'b0, phase_i[`NCO_QTR_W-1:0]};
    wire [11:0] x = quad[0] ? (`NCO_HALF_X - x_lo) : x_lo;

    // Odd polynomial instead of a table: no memory image needed,
    // error stays within ten output steps.
    wire [23:0] x_sq = x * x;
    wire [12:0] x2 = x_sq[23:`NCO_FRAC];
    wire [24:0] x_cu = x2 * x;
    wire [13:0] x3 = x_cu[24:`NCO_FRAC];
    wire [26:0] x_qu = x3 * x2;
    wire [15:0] x5 = x_qu[26:`NCO_FRAC];
    wire [31:0] t1 = {20'h0_0000, x} * `NCO_C1;
    wire [31:0] t3 = {18'h0_0000, x3} * `NCO_C3;
    wire [31:0] t5 = {16'h0000, x5} * `NCO_C5;
    wire [31:0] poly = t1 - t3 + t5;
    wire [19:0] mag_raw = poly[31:`NCO_CSH];
    wire [10:0] mag = (mag_raw > {9'h000, `NCO_MAG_MAX}) ? `NCO_MAG_MAX : mag_raw[10:0];

    // ----------------------------------------------------------------
    // Offset binary output
    // ----------------------------------------------------------------
    // R15: offset binary range
    // R21: registered output
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sample_o <= `NCO_MID;
        end else if (quad[1]) begin
            sample_o <= `NCO_MID - {1'b0, mag};
        end else begin
            sample_o <= `NCO_MID + {1'b0, mag};
        end
    end
endmodule

// ==== nco_sine_synth.v ====
// What this block does
// R1: Frequency from one of two tuning words
// R2: Phase bits 00/01/10/11 give 0/90/270/180
// R3: 64-bit shift register filled serially
// R4: Order input high MSB first, low LSB
// R5: Shift on shift clock rise while enabled
// R6: Offset added to top 13 phase bits
// R7: Phase code linear, 0x1000 is 180 degrees
// R8: Accumulator steps by tuning word each clock
// R9: Select high lower half, low upper half
// R10: Single word: select equals shift order
// R11: Transfer loads selected word to input register
// R12: Input register added every clock
// R13: Accumulate enable high holds accumulator
// R14: Load zeroes accumulator feedback
// R15: Sine output 0x001 to 0xfff, centre 0x800
// R16: Phase bits act after four clocks
// R17: Transfer sampled, acts after four clocks
// R18: Load acts after five clocks
// R19: Accumulate enable acts after four clocks
// R20: Accumulator wraps modulo 2^32
// R21: Sample output registered on clock edge
//
// Chosen here: the AHB-Lite register port and the register offsets.
`include "nco_defs.vh"

module nco_sine_synth #(
    parameter ADDR_W = 8
) (
    input wire mclk_i,
    input wire rst_n_i,
    input wire shift_clk_i,
    input wire shift_enable_n_i,
    input wire shift_msb_first_i,
    input wire serial_freq_in_i,
    input wire word_sel_lower_i,
    input wire transfer_word_n_i,
    input wire load_n_i,
    input wire accum_enable_n_i,
    input wire [1:0] phase_mod_bits_i,
    output wire [`NCO_OUT_W-1:0] sine_sample_out_o,
    input wire hsel_i,
    input wire [ADDR_W-1:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    output wire hreadyout_o,
    output wire hresp_o,
    output reg [31:0] hrdata_o
);
    // ----------------------------------------------------------------
    // Frequency shift register
    // ----------------------------------------------------------------
    reg [`NCO_FREQ_W-1:0] freq_reg;
    reg shift_clk_prev;
    wire shift_rise = shift_clk_i & ~shift_clk_prev;

    // Shift clock is sampled as a plain synchronous input, so it must
    // stay at or below half the main clock rate.
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_clk_prev <= 1'b0;
        end else begin
            shift_clk_prev <= shift_clk_i;
        end
    end

    // R3: serial fill
    // R5: edge and enable
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            freq_reg <= {`NCO_FREQ_W{1'b0}};
        end else if (shift_rise && !shift_enable_n_i) begin
            // R4: shift direction
            if (shift_msb_first_i) begin
                freq_reg <= {freq_reg[`NCO_FREQ_W-2:0], serial_freq_in_i};
            end else begin
                // R10: LSB first enters at top
                freq_reg <= {serial_freq_in_i, freq_reg[`NCO_FREQ_W-1:1]};
            end
        end
    end

    // ----------------------------------------------------------------
    // Control pipelines
    // ----------------------------------------------------------------
    wire transfer_d;
    wire sel_d;
    wire load_d;
    wire acc_en_d;
    wire [1:0] pm_d;
    reg [`NCO_CTRL_W-1:0] ctrl;
    wire [1:0] pm_src = ctrl[`NCO_CTRL_SOFT_PM_EN] ?
        ctrl[`NCO_CTRL_SOFT_PM_LO+1:`NCO_CTRL_SOFT_PM_LO] : phase_mod_bits_i;

    // R17: transfer delay, select travels with it
    nco_dly #(.W(2), .D(`NCO_TRANSFER_DLY), .RST(2'h1)) u_transfer_dly (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .d_i({word_sel_lower_i, transfer_word_n_i}),
        .q_o({sel_d, transfer_d})
    );

    // R18: load delay
    nco_dly #(.W(1), .D(`NCO_LOAD_DLY), .RST(1'b1)) u_load_dly (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .d_i(load_n_i),
        .q_o(load_d)
    );

    // R19: accumulate enable delay
    nco_dly #(.W(1), .D(`NCO_ACC_DLY), .RST(1'b1)) u_acc_dly (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .d_i(accum_enable_n_i),
        .q_o(acc_en_d)
    );

    // R16: phase bits delay
    nco_dly #(.W(2), .D(`NCO_PM_DLY), .RST(2'h0)) u_pm_dly (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .d_i(pm_src),
        .q_o(pm_d)
    );

    // ----------------------------------------------------------------
    // Phase accumulator
    // ----------------------------------------------------------------
    reg [`NCO_ACC_W-1:0] tune_reg;
    reg [`NCO_ACC_W-1:0] acc;
    reg [`NCO_ACC_W-1:0] next_acc;
    reg [`NCO_PH_W-1:0] phase;
    reg [1:0] qturn;

    // R1: word select
    // R9: select high picks lower half
    wire [`NCO_ACC_W-1:0] tune_mux = sel_d ? freq_reg[`NCO_ACC_W-1:0] :
        freq_reg[`NCO_FREQ_W-1:`NCO_ACC_W];

    // R11: transfer into input register
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tune_reg <= {`NCO_ACC_W{1'b0}};
        end else if (!transfer_d) begin
            tune_reg <= tune_mux;
        end
    end

    always @* begin
        next_acc = acc;
        // R13: enable high holds
        if (!acc_en_d) begin
            // R14: feedback zeroed
            if (!load_d) begin
                next_acc = tune_reg;
            end else begin
                // R8: step by tuning word
                // R12: add input register
                // R20: carry dropped
                next_acc = acc + tune_reg;
            end
        end
    end

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc <= {`NCO_ACC_W{1'b0}};
        end else begin
            acc <= next_acc;
        end
    end

    // ----------------------------------------------------------------
    // Phase offset adder
    // ----------------------------------------------------------------
    // R2: pin code to quarter turns
    always @* begin
        case (pm_d)
            2'h0: qturn = `NCO_QT_0;
            2'h1: qturn = `NCO_QT_90;
            2'h2: qturn = `NCO_QT_270;
            2'h3: qturn = `NCO_QT_180;
            default: qturn = `NCO_QT_0;
        endcase
    end

    // R6: add to top 13 bits
    // R7: 0x1000 is half a turn
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase <= {`NCO_PH_W{1'b0}};
        end else begin
            phase <= acc[`NCO_ACC_W-1:`NCO_PH_TOP] + {qturn, {`NCO_QTR_W{1'b0}}};
        end
    end

    // ----------------------------------------------------------------
    // Sine lookup
    // ----------------------------------------------------------------
    // R15: amplitude from phase
    nco_sine_rom u_rom (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .phase_i(phase),
        .sample_o(sine_sample_out_o)
    );

    // ----------------------------------------------------------------
    // AHB-Lite register slave
    // ----------------------------------------------------------------
    // Zero wait states: reads are decoded in the address phase and
    // registered so hrdata stands for the whole data phase.
    reg wr_pend;
    reg [ADDR_W-1:0] wr_addr;
    wire take = hsel_i & htrans_i[1] & hready_i;

    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_pend <= 1'b0;
            wr_addr <= {ADDR_W{1'b0}};
        end else if (hready_i) begin
            wr_pend <= take & hwrite_i;
            wr_addr <= haddr_i;
        end
    end

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl <= `NCO_CTRL_RST;
        end else if (wr_pend && wr_addr == `NCO_REG_CTRL) begin
            ctrl <= hwdata_i[`NCO_CTRL_W-1:0];
        end
    end

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (take && !hwrite_i) begin
            case (haddr_i)
                `NCO_REG_CTRL: hrdata_o <= {29'h0000_0000, ctrl};
                `NCO_REG_PHASE: hrdata_o <= acc;
                `NCO_REG_TUNE: hrdata_o <= tune_reg;
                `NCO_REG_FREQ_LO: hrdata_o <= freq_reg[`NCO_ACC_W-1:0];
                `NCO_REG_FREQ_HI: hrdata_o <= freq_reg[`NCO_FREQ_W-1:`NCO_ACC_W];
                `NCO_REG_SAMPLE: hrdata_o <= {20'h0_0000, sine_sample_out_o};
                default: hrdata_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// ==== nco_sine_synth_properties.sv ====
`include "nco_defs.vh"

module nco_chk #(
    parameter ADDR_W = 8
) (
    input wire mclk_i,
    input wire rst_n_i,
    input wire accum_enable_n_i,
    input wire load_n_i,
    input wire transfer_word_n_i,
    input wire [1:0] phase_mod_bits_i,
    input wire [`NCO_OUT_W-1:0] sine_sample_out_o,
    input wire hsel_i,
    input wire [ADDR_W-1:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire hready_i,
    input wire hreadyout_o,
    input wire hresp_o,
    input wire [31:0] hrdata_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    wire rd = hsel_i && htrans_i[1] && hready_i && !hwrite_i;
    // Register writes may switch the phase source, so they end a hold window
    wire wr = hsel_i && htrans_i[1] && hready_i && hwrite_i;

    property p_bus; hreadyout_o && !hresp_o; endproperty
    a_bus: assert property (p_bus) else $error("bus not ready or not okay");
    property p_range; sine_sample_out_o != 12'h000; endproperty
    a_range: assert property (p_range) else $error("sample below range");
    property p_hold;
        !wr ##1 accum_enable_n_i ##1 $stable(phase_mod_bits_i)
            |-> ##6 $stable(sine_sample_out_o);
    endproperty
    a_hold: assert property (p_hold) else $error("sample moved while held");
    // Zeroed feedback keeps the phase at the tuning word
    property p_load;
        !load_n_i ##1 (!load_n_i && transfer_word_n_i && !accum_enable_n_i && !wr)
            ##1 !accum_enable_n_i ##1 $stable(phase_mod_bits_i)
            |-> ##6 $stable(sine_sample_out_o);
    endproperty
    a_load: assert property (p_load) else $error("sample moved while loading");
    property p_rdhold; !rd |=> $stable(hrdata_o); endproperty
    a_rdhold: assert property (p_rdhold) else $error("read data changed without read");
    property p_rdsmp;
        rd && haddr_i == `NCO_REG_SAMPLE |=> hrdata_o == {20'h0, $past(sine_sample_out_o)};
    endproperty
    a_rdsmp: assert property (p_rdsmp) else $error("sample readback wrong");
    property p_unmap; rd && haddr_i > `NCO_REG_SAMPLE |=> hrdata_o == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_rst; $rose(rst_n_i) |-> (sine_sample_out_o == `NCO_MID) [*4]; endproperty
    a_rst: assert property (p_rst) else $error("sample not mid after reset");
endmodule

bind nco_sine_synth nco_chk #(.ADDR_W(ADDR_W)) nco_chk_i (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .accum_enable_n_i(accum_enable_n_i),
    .load_n_i(load_n_i),
    .transfer_word_n_i(transfer_word_n_i),
    .phase_mod_bits_i(phase_mod_bits_i),
    .sine_sample_out_o(sine_sample_out_o),
    .hsel_i(hsel_i),
    .haddr_i(haddr_i),
    .htrans_i(htrans_i),
    .hwrite_i(hwrite_i),
    .hready_i(hready_i),
    .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o),
    .hrdata_o(hrdata_o)
);

// ==== nco_host.sv ====
module nco_host (
    input wire mclk_i,
    output logic shift_clk_o,
    output logic shift_enable_n_o,
    output logic shift_msb_first_o,
    output logic serial_freq_in_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        shift_clk_o = 1'b0;
        shift_enable_n_o = 1'b1;
        shift_msb_first_o = 1'b1;
        serial_freq_in_o = 1'b0;
    end
    // one bit per rise, clock idle low
    task automatic send(input logic [63:0] w, input int n, input logic m, input logic en_n);
        int i;
        for (i = 0; i < n; i++) begin
            @(posedge mclk_i);
            shift_clk_o <= 1'b0;
            shift_enable_n_o <= en_n;
            shift_msb_first_o <= m;
            serial_freq_in_o <= m ? w[n-1-i] : w[i];
            @(posedge mclk_i);
            shift_clk_o <= 1'b1;
        end
        @(posedge mclk_i);
        shift_clk_o <= 1'b0;
        shift_enable_n_o <= 1'b1;
        // Released line flips so a stale bit is never mistaken for data
        serial_freq_in_o <= ~serial_freq_in_o;
    endtask
endmodule

// ==== nco_sine_synth_test.sv ====
module nco_sine_synth_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sel = 1'b0;
    logic transfer_n = 1'b1;
    logic load_n = 1'b1;
    logic acc_n = 1'b1;
    logic [1:0] pm = 2'h0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic sclk, sen_n, msb, ser_bit, rdy;
    logic [11:0] smp;
    logic [31:0] hrdata, q, q2;
    integer n_mismatch = 0;
    integer compares = 0;

    always #10 clk = ~clk;

    nco_host nco_host_i (.mclk_i(clk), .shift_clk_o(sclk), .shift_enable_n_o(sen_n),
        .shift_msb_first_o(msb), .serial_freq_in_o(ser_bit));
    nco_sine_synth nco_sine_synth_i (.mclk_i(clk), .rst_n_i(rst_n), .shift_clk_i(sclk),
        .shift_enable_n_i(sen_n), .shift_msb_first_i(msb), .serial_freq_in_i(ser_bit),
        .word_sel_lower_i(sel), .transfer_word_n_i(transfer_n), .load_n_i(load_n),
        .accum_enable_n_i(acc_n), .phase_mod_bits_i(pm), .sine_sample_out_o(smp),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(rdy), .hreadyout_o(rdy),
        .hresp_o(), .hrdata_o(hrdata));

    task tally_and_finish;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Bounded wait for hready at the next edges
    task rdy_wait;
        int k;
        k = 0;
        @(posedge clk);
        while (rdy !== 1'b1) begin
            k++;
            if (k > 50) begin
                n_mismatch++;
                tally_and_finish;
            end
            @(posedge clk);
        end
    endtask

    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        rdy_wait;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy_wait;
        r = hrdata;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_phase;
        int i;
        logic [11:0] old;
        logic [47:0] tbl;
        tbl = 48'h800_fff_001_800;
        old = 12'h800;
        for (i = 0; i < 4; i++) begin
            @(posedge clk);
            pm <= i[1:0];
            wt(5);
            #1 chk(smp, old);
            @(posedge clk);
            old = tbl[47-12*i -: 12];
            #1 chk(smp, old);
        end
        @(posedge clk);
        pm <= 2'h0;
        wt(8);
    endtask

    task t_regs;
        xfer(1'b1, 8'h00, 32'h6, q);
        xfer(1'b0, 8'h00, 32'h0, q);
        chk(q, 32'h6);
        xfer(1'b1, 8'h0c, 32'hffff_ffff, q);
        xfer(1'b1, 8'h18, 32'hffff_ffff, q);
        xfer(1'b0, 8'h18, 32'h0, q);
        chk(q, 32'h0);
        xfer(1'b0, 8'h0c, 32'h0, q);
        chk(q, 32'h0);
        xfer(1'b0, 8'h14, 32'h0, q);
        chk(q, 32'h800);
        xfer(1'b1, 8'h00, 32'h5, q);
        wt(8);
        xfer(1'b0, 8'h14, 32'h0, q);
        chk(q, 32'h001);
        xfer(1'b1, 8'h00, 32'h0, q);
    endtask

    task chk_freq(input logic [31:0] hi, input logic [31:0] lo);
        xfer(1'b0, 8'h10, 32'h0, q);
        chk(q, hi);
        xfer(1'b0, 8'h0c, 32'h0, q);
        chk(q, lo);
    endtask

    task t_shift;
        nco_host_i.send(64'h89ab_cdef, 32, 1'b0, 1'b0);
        chk_freq(32'h89ab_cdef, 32'h0);
        nco_host_i.send(64'h9000_0001_0123_4567, 64, 1'b1, 1'b0);
        chk_freq(32'h9000_0001, 32'h0123_4567);
        nco_host_i.send(64'h5a, 8, 1'b1, 1'b1);
        chk_freq(32'h9000_0001, 32'h0123_4567);
    endtask

    task tune(input logic s, input logic [31:0] e);
        sel <= s;
        transfer_n <= 1'b0;
        @(posedge clk);
        transfer_n <= 1'b1;
        wt(6);
        xfer(1'b0, 8'h08, 32'h0, q);
        chk(q, e);
    endtask

    task t_acc;
        load_n <= 1'b0;
        acc_n <= 1'b0;
        wt(8);
        xfer(1'b0, 8'h04, 32'h0, q);
        chk(q, 32'h9000_0001);
        load_n <= 1'b1;
        wt(8);
        xfer(1'b0, 8'h04, 32'h0, q);
        xfer(1'b0, 8'h04, 32'h0, q2);
        chk(q2 - q, 32'h2000_0002);
        acc_n <= 1'b1;
        wt(8);
        xfer(1'b0, 8'h04, 32'h0, q);
        xfer(1'b0, 8'h04, 32'h0, q2);
        chk(q2, q);
    endtask

    task t_rst;
        rst_n <= 1'b0;
        wt(2);
        #1 chk(smp, 32'h800);
        @(posedge clk);
        rst_n <= 1'b1;
        wt(1);
        chk_freq(32'h0, 32'h0);
    endtask

    initial begin
        wt(10);
        rst_n <= 1'b1;
        wt(2);
        t_phase;
        t_regs;
        t_shift;
        tune(1'b0, 32'h9000_0001);
        tune(1'b1, 32'h0123_4567);
        tune(1'b0, 32'h9000_0001);
        t_acc;
        t_rst;
        tally_and_finish;
    end
endmodule
